// ==== design/sew_defines.vh ====
// constants of the two-wire serial eeprom slave
// How it works
// R01: 16384-byte array, 256 pages of 64
// R02: write-protect high makes array read-only
// R03: open strap inputs read as low
// R04: falling data with clock high starts
// R05: rising data with clock high stops
// R06: one clock per bit, data moves low
// R07: receiver acknowledges by pulling data low
// R08: start abandons transfer, awaits new address
// R09: master clocks nine times, then starts
// R10: standby at power-up, idle stop, write end
// R11: upper address nibble must match type code
// R12: two select bits must match straps
// R13: address bit zero: one reads, zero writes
// R14: selected device acknowledges on ninth clock
// R15: byte write: address, two words, data, stop
// R16: stop launches self-timed programming, auto clear
// R17: programming disables inputs entirely
// R18: page write takes up to 63 more
// R19: acknowledge data, bump six low bits
// R20: past 64 bytes the page address wraps
// R21: whole page commits in one cycle
// R22: master starts only on an idle bus
// R23: no address acknowledge while still programming
// R24: address counter points past last access
// R25: word address is fourteen bits
// R26: protected writes acknowledged but never programmed
`ifndef SEW_DEFINES_VH
`define SEW_DEFINES_VH

// =========================================================
// array geometry
`define SEW_MEM_BYTES 16384
`define SEW_ADDR_W 14
`define SEW_PAGE_BYTES 64
`define SEW_PAGE_W 6
`define SEW_PAGE_NO_W 8

// =========================================================
// slave address layout
// device-type code, value is arbitrary
`define SEW_DEV_TYPE 4'h5
`define SEW_TYPE_HI 7
`define SEW_TYPE_LO 4
`define SEW_SEL_HI 3
`define SEW_SEL_LO 2
`define SEW_RW_BIT 0

// =========================================================
// timing
`define SEW_CLK_KHZ 10000
`define SEW_PROG_TIME_US 5000
`define SEW_PROG_CYCLES ((`SEW_PROG_TIME_US * `SEW_CLK_KHZ) / 1000)
`define SEW_CNT_W 16

// =========================================================
// byte phases of a transfer
`define SEW_PH_DEV 2'h0
`define SEW_PH_HI 2'h1
`define SEW_PH_LO 2'h2
`define SEW_PH_DATA 2'h3

`endif

// ==== design/sew_sync.v ====
// two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module sew_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// clock and reset
	input wire mclk_i,
	input wire rst_i,
	// pins in, synchronised out
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta;

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // sew_sync

// ==== design/sew_buf.v ====
// two-entry valid/ready buffer
`timescale 1ns/10ps
module sew_buf #(
	parameter W = 8
) (
	// clock and reset
	input wire mclk_i,
	input wire rst_i,
	// fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	// drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] d0;
	reg [W-1:0] d1;
	reg [1:0] cnt;
	wire push;
	wire pop;

	assign in_ready_o = (cnt != 2'h2);
	assign out_valid_o = (cnt != 2'h0);
	assign out_data_o = d0;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			d0 <= {W{1'b0}};
			d1 <= {W{1'b0}};
			cnt <= 2'h0;
		end else begin
			case ({push, pop})
			2'b10: begin
				if (cnt == 2'h0) begin
					d0 <= in_data_i;
				end else begin
					d1 <= in_data_i;
				end
				cnt <= cnt + 2'h1;
			end
			2'b01: begin
				d0 <= d1;
				cnt <= cnt - 2'h1;
			end
			2'b11: begin
				if (cnt == 2'h1) begin
					d0 <= in_data_i;
				end else begin
					d0 <= d1;
					d1 <= in_data_i;
				end
			end
			default: begin
				cnt <= cnt;
			end
			endcase
		end
	end
endmodule // sew_buf

// ==== design/sew_slave.v ====
// two-wire serial eeprom slave: bus engine, page buffer, array
`timescale 1ns/10ps
`include "sew_defines.vh"
module sew_slave #(
	parameter [3:0] DEV_TYPE = `SEW_DEV_TYPE,
	parameter PROG_CYCLES = `SEW_PROG_CYCLES,
	parameter CNT_W = `SEW_CNT_W
) (
	// clock and reset
	input wire mclk_i,
	input wire rst_i,
	// two-wire bus
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	// straps and protection
	input wire select_strap_low_i,
	input wire select_strap_high_i,
	input wire write_protect_i,
	// status
	output reg busy_o,
	output reg standby_o
);
	// =========================================================
	// constants
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_RX = 5'h02;
	localparam [4:0] ST_ACK = 5'h04;
	localparam [4:0] ST_TX = 5'h08;
	localparam [4:0] ST_MACK = 5'h10;
	localparam [31:0] PROG_LAST32 = PROG_CYCLES - 1;
	localparam [CNT_W-1:0] PROG_LAST = PROG_LAST32[CNT_W-1:0];
	localparam BW = `SEW_PAGE_W + 8;

	// =========================================================
	// storage
	reg [7:0] mem [0:`SEW_MEM_BYTES-1]; // R01
	reg [7:0] page_buf [0:`SEW_PAGE_BYTES-1]; // R01
	reg [`SEW_PAGE_BYTES-1:0] page_mask;

	// =========================================================
	// pin sampling
	wire [4:0] pins_s;
	wire scl_s;
	wire sda_s;
	wire wp_s;
	wire strap_hi_s;
	wire strap_lo_s;
	reg scl_q;
	reg sda_q;

	// open straps rely on a pad pull-down and reset low here
	sew_sync #(
		.W(5),
		.RST_VAL(5'h18)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.d_i({scl_i, sda_i, write_protect_i, select_strap_high_i, select_strap_low_i}),
		.q_o(pins_s)
	); // R03

	assign scl_s = pins_s[4];
	assign sda_s = pins_s[3];
	assign wp_s = pins_s[2];
	assign strap_hi_s = pins_s[1];
	assign strap_lo_s = pins_s[0];

	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire start_det = scl_s & scl_q & sda_q & ~sda_s; // R04 R06
	wire stop_det = scl_s & scl_q & ~sda_q & sda_s; // R05 R06
	wire line_toggle = (scl_s ^ scl_q) | (sda_s ^ sda_q);

	// =========================================================
	// data buffer between bus engine and page buffer
	reg buf_in_valid;
	reg [BW-1:0] buf_in_data;
	wire buf_in_ready;
	wire buf_out_valid;
	wire buf_out_ready;
	wire [BW-1:0] buf_out_data;
	reg committing;

	assign buf_out_ready = ~committing;

	sew_buf #(
		.W(BW)
	) u_buf (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.in_valid_i(buf_in_valid),
		.in_ready_o(buf_in_ready),
		.in_data_i(buf_in_data),
		.out_valid_o(buf_out_valid),
		.out_ready_i(buf_out_ready),
		.out_data_o(buf_out_data)
	);

	wire drain = buf_out_valid & buf_out_ready;
	wire [`SEW_PAGE_W-1:0] drain_idx = buf_out_data[BW-1:8];

	// =========================================================
	// helpers
	function addressed;
		input [7:0] b;
		input hi;
		input lo;
		begin
			addressed = (b[`SEW_TYPE_HI:`SEW_TYPE_LO] == DEV_TYPE) &&
				(b[`SEW_SEL_HI] == hi) && (b[`SEW_SEL_LO] == lo);
		end
	endfunction

	// =========================================================
	// bus engine state
	reg [4:0] state;
	reg [1:0] phase;
	reg [7:0] shreg;
	reg [7:0] txbyte;
	reg [3:0] bitcnt;
	reg rd_mode;
	reg [`SEW_ADDR_W-1:0] addr;
	reg [`SEW_PAGE_W-1:0] hi_byte;
	reg wr_pending;
	reg [`SEW_PAGE_W-1:0] commit_idx;
	reg [CNT_W-1:0] prog_cnt;

	wire [`SEW_PAGE_W-1:0] addr_low_inc = addr[`SEW_PAGE_W-1:0] + 6'h01;
	wire commit_we = committing & ~buf_out_valid & page_mask[commit_idx];

	// array and page buffer writes carry no reset, they are memories
	always @(posedge mclk_i) begin
		if (commit_we) begin
			mem[{addr[`SEW_ADDR_W-1:`SEW_PAGE_W], commit_idx}] <= page_buf[commit_idx]; // R21
		end
		if (drain) begin
			page_buf[drain_idx] <= buf_out_data[7:0]; // R20
		end
	end

	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			phase <= `SEW_PH_DEV;
			shreg <= 8'h00;
			txbyte <= 8'hFF;
			bitcnt <= 4'h0;
			rd_mode <= 1'b0;
			addr <= {`SEW_ADDR_W{1'b0}};
			hi_byte <= {`SEW_PAGE_W{1'b0}};
			wr_pending <= 1'b0;
			commit_idx <= {`SEW_PAGE_W{1'b0}};
			prog_cnt <= {CNT_W{1'b0}};
			committing <= 1'b0;
			page_mask <= {`SEW_PAGE_BYTES{1'b0}};
			buf_in_valid <= 1'b0;
			buf_in_data <= {BW{1'b0}};
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
			busy_o <= 1'b0;
			standby_o <= 1'b1; // R10
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			buf_in_valid <= 1'b0;
			if (drain) begin
				page_mask[drain_idx] <= 1'b1;
			end
			if (busy_o) begin
				// bus is ignored until the programming timer runs out
				state <= ST_IDLE; // R17 R23
				sda_oe_o <= 1'b0;
				if (committing && !buf_out_valid) begin
					commit_idx <= commit_idx + 6'h01;
					if (commit_idx == 6'h3F) begin
						committing <= 1'b0;
					end
				end
				if (prog_cnt == PROG_LAST && !committing) begin
					busy_o <= 1'b0; // R16
					standby_o <= 1'b1; // R10
					page_mask <= {`SEW_PAGE_BYTES{1'b0}};
				end else if (prog_cnt != PROG_LAST) begin
					prog_cnt <= prog_cnt + 1'b1;
				end
			end else begin
				if (line_toggle) begin
					standby_o <= 1'b0; // R10
				end
				if (start_det) begin
					// restart abandons whatever was in flight
					state <= ST_RX; // R04 R08
					phase <= `SEW_PH_DEV;
					bitcnt <= 4'h0;
					rd_mode <= 1'b0;
					wr_pending <= 1'b0;
					sda_oe_o <= 1'b0;
				end else if (stop_det) begin
					state <= ST_IDLE; // R05
					sda_oe_o <= 1'b0;
					wr_pending <= 1'b0;
					if (wr_pending && !wp_s) begin
						busy_o <= 1'b1; // R16 R02
						committing <= 1'b1; // R21
						commit_idx <= {`SEW_PAGE_W{1'b0}};
						prog_cnt <= {CNT_W{1'b0}};
					end else begin
						standby_o <= 1'b1; // R10 R26
					end
				end else begin
					case (state)
					ST_RX: begin
						if (scl_rise && bitcnt != 4'h8) begin
							shreg <= {shreg[6:0], sda_s}; // R06
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							case (phase)
							`SEW_PH_DEV: begin
								if (addressed(shreg, strap_hi_s, strap_lo_s)) begin // R11 R12
									sda_oe_o <= 1'b1; // R14
									state <= ST_ACK;
									rd_mode <= shreg[`SEW_RW_BIT]; // R13
									phase <= `SEW_PH_HI;
									if (shreg[`SEW_RW_BIT]) begin
										txbyte <= mem[addr];
										addr <= addr + 14'h0001; // R24
									end
								end else begin
									state <= ST_IDLE;
								end
							end
							`SEW_PH_HI: begin
								hi_byte <= shreg[`SEW_PAGE_W-1:0]; // R25
								sda_oe_o <= 1'b1; // R07 R15
								state <= ST_ACK;
								phase <= `SEW_PH_LO;
							end
							`SEW_PH_LO: begin
								addr <= {hi_byte, shreg}; // R25
								page_mask <= {`SEW_PAGE_BYTES{1'b0}};
								sda_oe_o <= 1'b1; // R07 R15
								state <= ST_ACK;
								phase <= `SEW_PH_DATA;
							end
							default: begin
								if (buf_in_ready) begin
									// protected data is still taken and acknowledged
									buf_in_valid <= 1'b1; // R26
									buf_in_data <= {addr[`SEW_PAGE_W-1:0], shreg};
									addr[`SEW_PAGE_W-1:0] <= addr_low_inc; // R19 R20 R24
									wr_pending <= 1'b1; // R18
									sda_oe_o <= 1'b1; // R19
									state <= ST_ACK;
								end else begin
									// no room: refuse rather than lose the byte
									state <= ST_IDLE;
								end
							end
							endcase
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							if (rd_mode) begin
								sda_oe_o <= ~txbyte[7]; // R06
								txbyte <= {txbyte[6:0], 1'b1};
								bitcnt <= 4'h1;
								state <= ST_TX;
							end else begin
								sda_oe_o <= 1'b0;
								bitcnt <= 4'h0;
								state <= ST_RX;
							end
						end
					end
					ST_TX: begin
						if (scl_fall) begin
							if (bitcnt == 4'h8) begin
								sda_oe_o <= 1'b0;
								state <= ST_MACK;
							end else begin
								sda_oe_o <= ~txbyte[7]; // R06
								txbyte <= {txbyte[6:0], 1'b1};
								bitcnt <= bitcnt + 4'h1;
							end
						end
					end
					ST_MACK: begin
						if (scl_rise) begin
							if (!sda_s) begin
								txbyte <= mem[addr]; // R07
								addr <= addr + 14'h0001; // R24
								state <= ST_ACK;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					default: begin
						state <= ST_IDLE; // R04
					end
					endcase
				end
			end
		end
	end
endmodule // sew_slave

// ==== testbench/sew_chk.sv ====
// pin assertions for the eeprom slave
`timescale 1ns/10ps
module sew_chk #(
	parameter PROG_CYCLES = 100
) (
	// pins
	input wire mclk_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe_o,
	input wire select_strap_low_i,
	input wire select_strap_high_i,
	input wire write_protect_i,
	input wire busy_o,
	input wire standby_o
);
	// =====
	// raw bus framing, seen ahead of the synchroniser
	reg frame;
	reg [3:0] since;
	reg [15:0] cnt;
	reg sda_d;
	// explicit previous value keeps the edge tests clear of clock inference
	wire sda_fell = scl_i && sda_d && !sda_i;
	wire sda_rose = scl_i && !sda_d && sda_i;
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			frame <= 1'b0;
			since <= 4'hF;
			cnt <= 16'h0;
			sda_d <= 1'b1;
		end else begin
			sda_d <= sda_i;
			if (sda_fell)
				frame <= 1'b1;
			else if (sda_rose)
				frame <= 1'b0;
			since <= sda_rose ? 4'h0 : since + {3'h0, since != 4'hF};
			cnt <= busy_o ? cnt + 16'h1 : 16'h0;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// =====
	// assertions
	property p_frame; sda_oe_o |-> frame && !sda_o; endproperty
	a_frame: assert property (p_frame) else $error("drive outside frame");
	property p_low; $changed(sda_oe_o) |-> !scl_i; endproperty
	a_low: assert property (p_low) else $error("data moved, clock high");
	property p_hold; $rose(sda_oe_o) |-> sda_oe_o [*6]; endproperty
	a_hold: assert property (p_hold) else $error("short pull");
	property p_quiet; busy_o |-> !sda_oe_o; endproperty
	a_quiet: assert property (p_quiet) else $error("drive while busy");
	property p_stby; busy_o |-> !standby_o; endproperty
	a_stby: assert property (p_stby) else $error("standby while busy");
	property p_wake; $fell(busy_o) |-> ##[0:2] standby_o; endproperty
	a_wake: assert property (p_wake) else $error("no standby");
	property p_go; $rose(busy_o) |-> since < 4'hA && !write_protect_i; endproperty
	a_go: assert property (p_go) else $error("bad launch");
	property p_len;
		$fell(busy_o) |-> cnt + 3 >= PROG_CYCLES && cnt <= PROG_CYCLES + 3;
	endproperty
	a_len: assert property (p_len) else $error("bad length");
endmodule // sew_chk

// ==== testbench/sew_mst.sv ====
// two-wire bus master model
`timescale 1ns/10ps
module sew_mst (
	// clock
	input wire clk_i,
	// bus
	input wire sda_i,
	output reg scl_o,
	output reg sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task w(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	// long low phase leaves room for the slave's late ack release
	task bt(input b, output r);
		begin
			sda_o <= b;
			w(3);
			scl_o <= 1'b1;
			w(1);
			r = sda_i;
			w(1);
			scl_o <= 1'b0;
			w(3);
		end
	endtask
	task start;
		begin
			sda_o <= 1'b1;
			w(3);
			scl_o <= 1'b1;
			w(2);
			sda_o <= 1'b0;
			w(2);
			scl_o <= 1'b0;
			w(3);
		end
	endtask
	task stop;
		begin
			sda_o <= 1'b0;
			w(3);
			scl_o <= 1'b1;
			w(2);
			sda_o <= 1'b1;
			w(4);
		end
	endtask
	task xb(input [7:0] d, input a9, output [7:0] q, output ak);
		integer i;
		reg r;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				bt(d[i], r);
				q[i] = r;
			end
			bt(a9, ak);
		end
	endtask
endmodule // sew_mst

// ==== testbench/testbench.sv ====
// self-checking bench for the eeprom slave
`timescale 1ns/10ps
`include "sew_defines.vh"
module testbench;
	localparam [7:0] DW = {`SEW_DEV_TYPE, 4'h8};
	localparam [7:0] DR = {`SEW_DEV_TYPE, 4'h9};
	reg mclk_i = 1'b0;
	reg rst_i = 1'b1;
	reg wp = 1'b0;
	reg [1:0] strap = 2'h2;
	integer num_errors = 0;
	integer comparisons = 0;
	integer nb = 0;
	integer j;
	reg [7:0] q;
	reg ak;
	wire scl;
	wire sdm;
	wire oe;
	wire busy;
	wire stby;
	wire sda = sdm & ~oe;
	always #50 mclk_i = ~mclk_i;
	always @(posedge busy) nb = nb + 1;
	sew_mst mst (.clk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_o(sdm));
	sew_slave #(.PROG_CYCLES(200)) sew_slave_i (.mclk_i(mclk_i), .rst_i(rst_i),
		.scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe), .select_strap_low_i(strap[0]),
		.select_strap_high_i(strap[1]), .write_protect_i(wp), .busy_o(busy), .standby_o(stby));
	task chk(input [7:0] s, input [7:0] e);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				num_errors = num_errors + 1;
				$display("[ERR] %0t saw %h want %h", $time, s, e);
			end
		end
	endtask
	task tk(input integer n);
		repeat (n) @(posedge mclk_i);
	endtask
	task wb(input [7:0] d, input e);
		begin
			mst.xb(d, 1'b1, q, ak);
			chk({7'h0, ak}, {7'h0, e});
		end
	endtask
	task seek(input [7:0] hi, input [7:0] lo);
		begin
			mst.start;
			wb(DW, 1'b0);
			wb(hi, 1'b0);
			wb(lo, 1'b0);
			mst.start;
			wb(DR, 1'b0);
		end
	endtask
	task rd1(input [7:0] e);
		begin
			mst.xb(8'hFF, 1'b1, q, ak);
			chk(q, e);
			mst.stop;
		end
	endtask
	task wbusy;
		begin
			j = 0;
			while (busy !== 1'b0 && j < 400) begin
				tk(1);
				j = j + 1;
			end
			chk({6'h0, busy, stby}, 8'h1);
		end
	endtask
	task t_select;
		integer s;
		integer p;
		begin
			chk({6'h0, busy, stby}, 8'h1);
			for (p = 0; p < 4; p = p + 1) begin
				strap <= p[1:0];
				for (s = 0; s < 4; s = s + 1) begin
					mst.start;
					chk({7'h0, stby}, 8'h0);
					wb({`SEW_DEV_TYPE, s[1:0], 2'b00}, s != p);
					mst.stop;
				end
			end
			strap <= 2'h2;
			mst.start;
			wb(8'h68, 1'b1);
			mst.stop;
			tk(8);
			chk({7'h0, stby}, 8'h1);
		end
	endtask
	task t_byte;
		begin
			mst.start;
			wb(DW, 1'b0);
			wb(8'hC3, 1'b0);
			wb(8'h21, 1'b0);
			wb(8'h5A, 1'b0);
			mst.stop;
			tk(10);
			chk({7'h0, busy}, 8'h1);
			mst.start;
			wb(DW, 1'b1);
			mst.stop;
			wbusy;
			seek(8'h03, 8'h21);
			rd1(8'h5A);
		end
	endtask
	task t_page;
		integer k;
		begin
			mst.start;
			wb(DW, 1'b0);
			wb(8'h01, 1'b0);
			wb(8'h7E, 1'b0);
			for (k = 0; k < 66; k = k + 1)
				wb(k[7:0] + 8'h10, 1'b0);
			k = nb;
			mst.stop;
			tk(10);
			wbusy;
			chk(nb[7:0] - k[7:0], 8'h1);
			mst.start;
			wb(DR, 1'b0);
			rd1(8'h12);
			seek(8'h01, 8'h40);
			for (k = 0; k < 64; k = k + 1) begin
				mst.xb(8'hFF, k == 63, q, ak);
				chk(q, k[7:0] + 8'h12);
			end
			mst.stop;
		end
	endtask
	task t_wp;
		integer k;
		begin
			wp <= 1'b1;
			k = nb;
			mst.start;
			wb(DW, 1'b0);
			wb(8'h03, 1'b0);
			wb(8'h21, 1'b0);
			wb(8'hA5, 1'b0);
			mst.stop;
			tk(20);
			chk({nb[6:0] - k[6:0], stby}, 8'h1);
			wp <= 1'b0;
			seek(8'h03, 8'h21);
			rd1(8'h5A);
		end
	endtask
	task t_abort;
		integer k;
		begin
			mst.start;
			wb(DW, 1'b0);
			wb(8'h03, 1'b0);
			wb(8'h21, 1'b0);
			// a whole data byte leaves a write pending that the restart must drop
			wb(8'hEE, 1'b0);
			k = nb;
			for (j = 0; j < 4; j = j + 1) begin
				mst.bt(1'b1, ak);
				chk({7'h0, ak}, 8'h1);
			end
			seek(8'h03, 8'h21);
			rd1(8'h5A);
			tk(20);
			chk(nb[7:0] - k[7:0], 8'h0);
		end
	endtask
	task give_verdict;
		begin
			$display("errors %0d comparisons %0d", num_errors, comparisons);
			if (num_errors == 0 && comparisons > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		tk(20);
		rst_i <= 1'b0;
		tk(5);
		t_select;
		t_byte;
		t_page;
		t_wp;
		t_abort;
		give_verdict;
	end
	// about twice the expected run
	initial begin
		#3000000;
		num_errors = num_errors + 1;
		give_verdict;
	end
endmodule // testbench
bind sew_slave sew_chk #(.PROG_CYCLES(PROG_CYCLES)) sew_chk_i (.mclk_i(mclk_i),
	.rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.select_strap_low_i(select_strap_low_i), .select_strap_high_i(select_strap_high_i),
	.write_protect_i(write_protect_i), .busy_o(busy_o), .standby_o(standby_o));
